// ===== common/port_override_map.svh
// register offsets, reset values and bus codes for the port override block
`ifndef PORT_OVERRIDE_MAP_SVH
`define PORT_OVERRIDE_MAP_SVH

`define PO_NPIN 4
`define PO_ADDR_W 8
`define PO_ADDR_PIN 8'h00
`define PO_ADDR_DIR 8'h04
`define PO_ADDR_DATA 8'h08
`define PO_ADDR_PULL 8'h0C
`define PO_ADDR_STATUS 8'h10
`define PO_RST_DIR 4'h0
`define PO_RST_DATA 4'h0
`define PO_RST_PULL 4'h0
`define PO_RST_PINS 4'h0
`define PO_RST_RDATA 32'h0000_0000
`define PO_RST_SYNC 2'h0
`define PO_HSIZE_WORD 3'h2
`define PO_HRESP_OKAY 1'h0
`define PO_ZERO4 4'h0
`define PO_ONE1 1'h1
`define PO_ZERO1 1'h0

`endif

// ===== common/port_override_pkg.sv
// types shared by the port override block
`include "port_override_map.svh"

package port_override_pkg;

    typedef logic [`PO_NPIN-1:0] pins_t;

    typedef struct packed {
        pins_t dirReg;
        pins_t dataReg;
        pins_t pullReg;
        pins_t pinSync1;
        pins_t pinSync2;
        logic dpWrite;
        logic [`PO_ADDR_W-1:0] dpAddr;
        pins_t pullupEn;
        pins_t driveEn;
        pins_t padOutReg;
        pins_t inputEn;
        pins_t altIn;
        logic [31:0] hrdata;
        logic hreadyout;
    } port_state_t;

    typedef struct packed {
        logic [1:0] stage;
    } sync_state_t;

endpackage

// ===== logic/pin_override_cell.sv
// per-pin multiplexing of general-purpose controls against alternate-function overrides
`timescale 1ns/1ps
module pin_override_cell
(
    // general-purpose port bits
    input wire logic pullupEnableBit,
    input wire logic directionBit,
    input wire logic portDataBit,
    input wire logic sleepClamp,
    input wire logic padIn,
    // overrides from the alternate function
    input wire logic pullupOverrideEn,
    input wire logic pullupOverrideVal,
    input wire logic dirOverrideEn,
    input wire logic dirOverrideVal,
    input wire logic valueOverrideEn,
    input wire logic valueOverrideVal,
    input wire logic toggleOverrideEn,
    input wire logic inputEnOverrideEn,
    input wire logic inputEnOverrideVal,
    // resolved pin controls
    output logic pullupOn,
    output logic drive,
    output logic value,
    output logic inputEn,
    output logic altDigitalIn
);
    logic dataEff;

    always_comb
    begin
        dataEff = portDataBit ^ toggleOverrideEn; // [RULE4]
        pullupOn = pullupOverrideEn ? pullupOverrideVal : pullupEnableBit; // [RULE1]
        drive = dirOverrideEn ? dirOverrideVal : directionBit; // [RULE2]
        value = valueOverrideEn ? valueOverrideVal : dataEff; // [RULE3]
        inputEn = inputEnOverrideEn ? inputEnOverrideVal : !sleepClamp; // [RULE5]
        // clamped to ground when the input buffer is off
        altDigitalIn = padIn & inputEn; // [RULE6]
    end
endmodule // pin_override_cell

// ===== logic/port_override_top.sv
// port override block: AHB-Lite port registers plus per-pin alternate-function muxing
// Function
// [RULE1] pull-up follows override value when enabled, else the pull-up enable bit
// [RULE2] driver follows direction override value when enabled, else the direction bit
// [RULE3] driven level is value override when enabled, else port data bit
// [RULE4] toggle override inverts port data; tied inactive on all pins here
// [RULE5] input enable follows override when enabled, else clamped in deep sleep
// [RULE6] alternate digital input taken after Schmitt trigger, before port synchroniser
// [RULE7] bit 3 reset function forces pull-up on, driver off, no value override
// [RULE8] clock-out flag makes bit 2 drive system clock, pull-up off, driver on
// [RULE9] bit 0 outputs compare A waveform while its enable is active
// [RULE10] bit 1 outputs compare B waveform when enabled and no external clock
// [RULE11] external clock select forces bit 1 pull-up and driver off, input on unless in power-down
// [RULE12] pin-change mask with group enable, or ADC disable, overrides input enable
// [RULE13] enabled external interrupt 0 keeps bit 2 input enabled in sleep
// [RULE14] software sets comparator pins as inputs with pull-up off
// [RULE15] port strobes and sleep shared; every override generated per pin
// [RULE16] pin inputs routed to pin-change, clock, capture, interrupt and count inputs
// [RULE17] overrides reach pin controls with no latency beyond register timing
`timescale 1ns/1ps
`include "port_override_map.svh"
module port_override_top
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // configuration flags and sleep
    input wire logic resetPinDisableFlag,
    input wire logic clockOutFlag,
    input wire logic selectA,
    input wire logic powerDownState,
    input wire logic sleepClamp,
    // peripheral override sources
    input wire logic compareAEn,
    input wire logic compareAWave,
    input wire logic compareBEn,
    input wire logic compareBWave,
    input wire logic extIrq0En,
    input wire logic [3:0] pinChangeMask,
    input wire logic pinChangeGroupEn,
    input wire logic [3:0] adcDigitalDisableBit,
    // pads
    input wire logic [3:0] padIn,
    output logic [3:0] padOut,
    output logic [3:0] padOe,
    output logic [3:0] pullupEn,
    // alternate digital inputs
    output logic [3:0] pinChangeSrc,
    output logic extClockIn,
    output logic captureInput,
    output logic extIrq0In,
    output logic timerCountSrc
);
    port_override_pkg::port_state_t st_reg;
    port_override_pkg::port_state_t st_next;
    logic rstSyncB;
    logic addrTake;
    logic wrHit;
    port_override_pkg::pins_t dir_next;
    port_override_pkg::pins_t data_next;
    port_override_pkg::pins_t pull_next;
    port_override_pkg::pins_t pullupOverrideEn, pullupOverrideVal, dirOverrideEn, dirOverrideVal;
    port_override_pkg::pins_t valueOverrideEn, valueOverrideVal, toggleOverrideEn;
    port_override_pkg::pins_t inputEnOverrideEn, inputEnOverrideVal;
    port_override_pkg::pins_t cellPull, cellDrive, cellValue, cellIe, cellAlt;
    logic rstPinActive;
    logic pinChange0, pinChange1, pinChange2, pinChange3;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    reset_sync u_reset_sync
    (
        .clk(clk),
        .rst_b(rst_b),
        .rstSyncB(rstSyncB)
    );

    // ------------------------------------------------------------
    // register decode helpers
    // ------------------------------------------------------------
    function automatic logic regHit(input logic [`PO_ADDR_W-1:0] addr,
                                    input logic [`PO_ADDR_W-1:0] target);
        regHit = (addr == target);
    endfunction

    function automatic logic [31:0] readMux(input logic [`PO_ADDR_W-1:0] addr,
                                            input port_override_pkg::port_state_t s);
        readMux = `PO_RST_RDATA;
        if (regHit(addr, `PO_ADDR_PIN))
            readMux[3:0] = s.pinSync2;
        if (regHit(addr, `PO_ADDR_DIR))
            readMux[3:0] = s.dirReg;
        if (regHit(addr, `PO_ADDR_DATA))
            readMux[3:0] = s.dataReg;
        if (regHit(addr, `PO_ADDR_PULL))
            readMux[3:0] = s.pullReg;
        if (regHit(addr, `PO_ADDR_STATUS))
            readMux[11:0] = {s.inputEn, s.pullupEn, s.driveEn};
    endfunction

    // ------------------------------------------------------------
    // register write values, visible to the pin muxing in the same cycle
    // ------------------------------------------------------------
    assign wrHit = st_reg.dpWrite;
    assign dir_next = (wrHit && regHit(st_reg.dpAddr, `PO_ADDR_DIR)) ? hwdata[3:0]
                      : st_reg.dirReg;
    // writing ones to the pin register toggles the data bits
    assign data_next = (wrHit && regHit(st_reg.dpAddr, `PO_ADDR_DATA)) ? hwdata[3:0]
                       : (wrHit && regHit(st_reg.dpAddr, `PO_ADDR_PIN))
                         ? (st_reg.dataReg ^ hwdata[3:0]) : st_reg.dataReg;
    assign pull_next = (wrHit && regHit(st_reg.dpAddr, `PO_ADDR_PULL)) ? hwdata[3:0]
                       : st_reg.pullReg;
    assign addrTake = hsel && htrans[1] && hready;

    // ------------------------------------------------------------
    // per-pin override terms
    // ------------------------------------------------------------
    assign rstPinActive = !resetPinDisableFlag;
    assign pinChange0 = pinChangeMask[0] && pinChangeGroupEn;
    assign pinChange1 = pinChangeMask[1] && pinChangeGroupEn;
    assign pinChange2 = pinChangeMask[2] && pinChangeGroupEn;
    assign pinChange3 = pinChangeMask[3] && pinChangeGroupEn;

    always_comb
    begin
        toggleOverrideEn = `PO_ZERO4; // [RULE4]
        // bit 0: compare A output
        pullupOverrideEn[0] = `PO_ZERO1;
        pullupOverrideVal[0] = `PO_ZERO1;
        dirOverrideEn[0] = `PO_ZERO1;
        dirOverrideVal[0] = `PO_ZERO1;
        valueOverrideEn[0] = compareAEn; // [RULE9]
        valueOverrideVal[0] = compareAWave; // [RULE9]
        inputEnOverrideEn[0] = pinChange0 || adcDigitalDisableBit[0]; // [RULE12]
        inputEnOverrideVal[0] = pinChange0; // [RULE12]
        // bit 1: external clock, compare B
        pullupOverrideEn[1] = selectA; // [RULE11]
        pullupOverrideVal[1] = `PO_ZERO1;
        dirOverrideEn[1] = selectA; // [RULE11]
        dirOverrideVal[1] = `PO_ZERO1;
        valueOverrideEn[1] = selectA || compareBEn; // [RULE10]
        valueOverrideVal[1] = !selectA && compareBWave; // [RULE10]
        inputEnOverrideEn[1] = selectA || pinChange1 || adcDigitalDisableBit[1]; // [RULE12]
        inputEnOverrideVal[1] = (selectA && !powerDownState)
                                || (!selectA && pinChange1); // [RULE11]
        // bit 2: clock out, external interrupt 0
        pullupOverrideEn[2] = clockOutFlag; // [RULE8]
        pullupOverrideVal[2] = `PO_ZERO1;
        dirOverrideEn[2] = clockOutFlag; // [RULE8]
        dirOverrideVal[2] = `PO_ONE1;
        valueOverrideEn[2] = clockOutFlag;
        valueOverrideVal[2] = `PO_ZERO1;
        inputEnOverrideEn[2] = pinChange2 || adcDigitalDisableBit[2] || extIrq0En; // [RULE13]
        inputEnOverrideVal[2] = pinChange2 || extIrq0En; // [RULE13]
        // bit 3: reset pin
        pullupOverrideEn[3] = rstPinActive; // [RULE7]
        pullupOverrideVal[3] = `PO_ONE1; // [RULE7]
        dirOverrideEn[3] = rstPinActive; // [RULE7]
        dirOverrideVal[3] = `PO_ZERO1; // [RULE7]
        valueOverrideEn[3] = `PO_ZERO1; // [RULE7]
        valueOverrideVal[3] = `PO_ZERO1;
        inputEnOverrideEn[3] = rstPinActive || pinChange3 || adcDigitalDisableBit[3]; // [RULE12]
        inputEnOverrideVal[3] = resetPinDisableFlag && pinChange3; // [RULE12]
    end

    // ------------------------------------------------------------
    // pin cells, one per bit with its own override set
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < `PO_NPIN; i++)
        begin : g_pin
            pin_override_cell u_cell // [RULE15]
            (
                .pullupEnableBit(pull_next[i]),
                .directionBit(dir_next[i]),
                .portDataBit(data_next[i]),
                .sleepClamp(sleepClamp),
                .padIn(padIn[i]),
                .pullupOverrideEn(pullupOverrideEn[i]),
                .pullupOverrideVal(pullupOverrideVal[i]),
                .dirOverrideEn(dirOverrideEn[i]),
                .dirOverrideVal(dirOverrideVal[i]),
                .valueOverrideEn(valueOverrideEn[i]),
                .valueOverrideVal(valueOverrideVal[i]),
                .toggleOverrideEn(toggleOverrideEn[i]),
                .inputEnOverrideEn(inputEnOverrideEn[i]),
                .inputEnOverrideVal(inputEnOverrideVal[i]),
                .pullupOn(cellPull[i]),
                .drive(cellDrive[i]),
                .value(cellValue[i]),
                .inputEn(cellIe[i]),
                .altDigitalIn(cellAlt[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.pinSync1 = padIn;
        st_next.pinSync2 = st_reg.pinSync1;
        st_next.dpWrite = addrTake && hwrite && (hsize == `PO_HSIZE_WORD);
        st_next.dpAddr = haddr[`PO_ADDR_W-1:0];
        st_next.hrdata = addrTake && !hwrite ? readMux(haddr[`PO_ADDR_W-1:0], st_reg)
                         : `PO_RST_RDATA;
        st_next.hreadyout = `PO_ONE1;
        st_next.dirReg = dir_next;
        st_next.dataReg = data_next;
        st_next.pullReg = pull_next;
        // pin controls settle on the same edge as the register write
        st_next.pullupEn = cellPull; // [RULE17]
        st_next.driveEn = cellDrive; // [RULE17]
        st_next.padOutReg = cellValue;
        st_next.inputEn = cellIe;
        st_next.altIn = cellAlt;
    end

    always_ff @(posedge clk or negedge rstSyncB)
    begin
        if (!rstSyncB)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout = st_reg.hreadyout;
    assign hrdata = st_reg.hrdata;
    assign hresp = `PO_HRESP_OKAY;
    assign pullupEn = st_reg.pullupEn;
    assign padOe = st_reg.driveEn;
    // the system clock itself cannot pass through a flip-flop
    assign padOut = {st_reg.padOutReg[3], clockOutFlag ? clk : st_reg.padOutReg[2],
                     st_reg.padOutReg[1:0]}; // [RULE8]
    assign pinChangeSrc = st_reg.altIn; // [RULE16]
    assign extClockIn = st_reg.altIn[1]; // [RULE16]
    assign captureInput = st_reg.altIn[1]; // [RULE16]
    assign extIrq0In = st_reg.altIn[2];
    assign timerCountSrc = st_reg.altIn[2]; // [RULE16]

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSyncB);

    reset_pullup_a: assert property (!resetPinDisableFlag |=> pullupEn[3] && !padOe[3]) // [RULE7]
        else $error("reset pin pull-up or driver wrong");
    clock_out_a: assert property (clockOutFlag |=> padOe[2] && !pullupEn[2]) // [RULE8]
        else $error("clock out pin not driven");
    compare_a_a: assert property (compareAEn |=> padOut[0] == $past(compareAWave)) // [RULE9]
        else $error("compare A waveform missing");
    compare_b_a: assert property (compareBEn && !selectA
                                  |=> padOut[1] == $past(compareBWave)) // [RULE10]
        else $error("compare B waveform missing");
    select_a_a: assert property (selectA && !powerDownState
                                  |=> !padOe[1] && !pullupEn[1] && pinChangeSrc[1]
                                      == $past(padIn[1])) // [RULE11]
        else $error("external clock pin wrong");
    dir_follow_a: assert property (padOe[0] == st_reg.dirReg[0]) // [RULE2]
        else $error("bit 0 driver not following direction");
    pull_follow_a: assert property (pullupEn[1] == (selectA ? 1'h0 : st_reg.pullReg[1]) ||
                                    $changed(selectA)) // [RULE1]
        else $error("bit 1 pull-up wrong");
    data_follow_a: assert property (!compareAEn |=> padOut[0] == st_reg.dataReg[0]) // [RULE3]
        else $error("bit 0 data value wrong");
    adc_disable_a: assert property (adcDigitalDisableBit[0] && !pinChange0
                                    |=> !st_reg.inputEn[0] && !pinChangeSrc[0]) // [RULE12]
        else $error("ADC disable did not clamp input");
    irq_wake_a: assert property (extIrq0En && sleepClamp
                                 |=> st_reg.inputEn[2] && extIrq0In == $past(padIn[2])) // [RULE13]
        else $error("interrupt pin clamped in sleep");
    sleep_clamp_a: assert property (sleepClamp && !pinChange0 && !adcDigitalDisableBit[0]
                                    |=> !st_reg.inputEn[0]) // [RULE5]
        else $error("bit 0 input not clamped in sleep");
    write_dir_a: assert property (st_reg.dpWrite && st_reg.dpAddr == `PO_ADDR_DIR
                                  |=> padOe[0] == $past(hwdata[0])) // [RULE17]
        else $error("direction write late at pin");

    write_cover_c: cover property (st_reg.dpWrite ##1 padOe != $past(padOe));
    clkout_cover_c: cover property (clockOutFlag ##1 padOe[2]);
    compare_cover_c: cover property (compareAEn && compareBEn && !selectA);
    read_cover_c: cover property (addrTake && !hwrite ##1 hrdata != `PO_RST_RDATA);
endmodule // port_override_top

// ===== logic/reset_sync.sv
// two-stage release of the asynchronous active-low reset
`timescale 1ns/1ps
`include "port_override_map.svh"
module reset_sync
(
    // clock and raw reset
    input wire logic clk,
    input wire logic rst_b,
    // synchronised reset
    output logic rstSyncB
);
    port_override_pkg::sync_state_t st_reg;
    port_override_pkg::sync_state_t st_next;

    always_comb
    begin
        st_next.stage = {st_reg.stage[0], `PO_ONE1};
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg.stage <= `PO_RST_SYNC;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rstSyncB = st_reg.stage[1];
endmodule // reset_sync

// ===== verif/periph_override_model.sv
// behavioural model of the on-chip peripherals that feed the pin overrides
`timescale 1ns/1ps
module periph_override_model
(
    // clock and commanded settings
    input wire logic clk,
    input wire logic slow,
    input wire logic [13:0] cmd,
    // timer compare overrides
    output logic compareAEn,
    output logic compareAWave,
    output logic compareBEn,
    output logic compareBWave,
    // interrupt and analog input controls
    output logic extIrq0En,
    output logic [3:0] pinChangeMask,
    output logic pinChangeGroupEn,
    output logic [3:0] adcDigitalDisableBit
);
    // ---------------------------------------------------------------
    // settings reach the pins after one or two clock edges
    // ---------------------------------------------------------------
    logic [13:0] stage1 = 14'h0000;
    logic [13:0] live = 14'h0000;

    always @(posedge clk)
    begin
        stage1 <= cmd;
        live <= slow ? stage1 : cmd;
    end

    // compare A and compare B each get their own enable and waveform
    assign compareAEn = live[0];
    assign compareAWave = live[1];
    assign compareBEn = live[2];
    assign compareBWave = live[3];
    assign extIrq0En = live[4];
    assign pinChangeMask = live[8:5];
    assign pinChangeGroupEn = live[9];
    assign adcDigitalDisableBit = live[13:10];
endmodule // periph_override_model

// ===== verif/port_alternate_function_override_tb_top.sv
// self-checking bench for the port alternate-function override block
`timescale 1ns/1ps
module port_alternate_function_override_tb_top;
    // ---------------------------------------------------------------
    // stimulus and wiring
    // ---------------------------------------------------------------
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    // [0] reset-pin disable, [1] clock out, [2] select_a, [3] power down, [4] sleep
    // [18:5] peripheral command, [22:19] pad levels
    logic [22:0] cfg = 23'h000001;
    logic slow = 1'h0;
    logic hreadyout, hresp, extClockIn, captureInput, extIrq0In, timerCountSrc;
    logic [31:0] hrdata, rd;
    logic [3:0] padOut, padOe, pullupEn, pinChangeSrc, pinChangeMask, adcDigitalDisableBit;
    logic compareAEn, compareAWave, compareBEn, compareBWave, extIrq0En, pinChangeGroupEn;
    logic [15:0] e;
    logic [3:0] m;
    int failures = 0;
    int n_checks = 0;
    logic [22:0] cases [10] = '{23'h780001, 23'h780000, 23'h780003, 23'h780005, 23'h78000D,
        23'h7801E1, 23'h7801A5, 23'h78EA11, 23'h2B3C11, 23'h786000};

    always #50 clk = ~clk;

    port_override_top port_override_top_i (.clk(clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .resetPinDisableFlag(cfg[0]), .clockOutFlag(cfg[1]), .selectA(cfg[2]),
        .powerDownState(cfg[3]), .sleepClamp(cfg[4]), .compareAEn(compareAEn),
        .compareAWave(compareAWave), .compareBEn(compareBEn), .compareBWave(compareBWave),
        .extIrq0En(extIrq0En), .pinChangeMask(pinChangeMask),
        .pinChangeGroupEn(pinChangeGroupEn), .adcDigitalDisableBit(adcDigitalDisableBit),
        .padIn(cfg[22:19]), .padOut(padOut), .padOe(padOe), .pullupEn(pullupEn),
        .pinChangeSrc(pinChangeSrc), .extClockIn(extClockIn), .captureInput(captureInput),
        .extIrq0In(extIrq0In), .timerCountSrc(timerCountSrc));

    periph_override_model periph_override_model_i (.clk(clk), .slow(slow), .cmd(cfg[18:5]),
        .compareAEn(compareAEn), .compareAWave(compareAWave), .compareBEn(compareBEn),
        .compareBWave(compareBWave), .extIrq0En(extIrq0En), .pinChangeMask(pinChangeMask),
        .pinChangeGroupEn(pinChangeGroupEn), .adcDigitalDisableBit(adcDigitalDisableBit));

    // ---------------------------------------------------------------
    // reporting and bus access
    // ---------------------------------------------------------------
    task automatic conclude();
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic checkPins(input logic [3:0] got, input logic [3:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one single word transfer; read data taken at the edge that ends the data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        n = 0;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'h1 && n < 20);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'h1 && n < 40);
        q = hrdata;
        if (n >= 40)
        begin
            failures++;
            $display("MISMATCH at %0t: bus transfer never completed", $time);
            conclude();
        end
    endtask

    // pin controls expected with DIR=F, DATA=A, PULL=5: {inputEn, value, drive, pull-up}
    function automatic logic [15:0] expected(input logic [22:0] c);
        logic [3:0] pu, oe, vl, ie, pcg;
        pcg = c[13:10] & {4{c[14]}};
        pu = 4'h5;
        oe = 4'hF;
        vl = 4'hA;
        ie = {4{~c[4]}};
        vl[0] = c[5] ? c[6] : vl[0];
        ie[0] = (pcg[0] | c[15]) ? pcg[0] : ie[0];
        pu[1] = c[2] ? 1'h0 : pu[1];
        oe[1] = c[2] ? 1'h0 : oe[1];
        vl[1] = (c[2] | c[7]) ? (~c[2] & c[8]) : vl[1];
        ie[1] = (c[2] | pcg[1] | c[16]) ? ((c[2] & ~c[3]) | (~c[2] & pcg[1])) : ie[1];
        pu[2] = c[1] ? 1'h0 : pu[2];
        oe[2] = c[1] ? 1'h1 : oe[2];
        ie[2] = (pcg[2] | c[17] | c[9]) ? (pcg[2] | c[9]) : ie[2];
        pu[3] = ~c[0] ? 1'h1 : pu[3];
        oe[3] = ~c[0] ? 1'h0 : oe[3];
        ie[3] = (~c[0] | pcg[3] | c[18]) ? (c[0] & pcg[3]) : ie[3];
        return {ie, vl, oe, pu};
    endfunction

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        checkPins(padOe | pullupEn, 4'h0, "pads in reset");
        checkWord({31'h0, hreadyout}, 32'h0, "ready in reset");
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        for (int a = 0; a < 24; a += 4)
        begin
            ahb(1'h0, a, 32'h0, rd);
            if (a != 16)
                checkWord(rd, 32'h0, "register reset value");
        end
        ahb(1'h1, 32'h0C, 32'hFFFF_FFF5, rd);
        ahb(1'h1, 32'h08, 32'h0000_000A, rd);
        ahb(1'h1, 32'h04, 32'h0000_000F, rd);
        #1;
        checkPins(padOe, 4'hF, "drive on register edge");
        ahb(1'h0, 32'h0C, 32'h0, rd);
        checkWord(rd, 32'h5, "pull-up register readback");
        ahb(1'h1, 32'h00, 32'h3, rd);
        ahb(1'h0, 32'h08, 32'h0, rd);
        checkWord(rd, 32'h9, "data toggled by pin write");
        ahb(1'h1, 32'h00, 32'h3, rd);
        ahb(1'h1, 32'h14, 32'hF, rd);
        ahb(1'h0, 32'h14, 32'h0, rd);
        checkWord(rd, 32'h0, "unmapped address");
        checkWord({31'h0, hresp}, 32'h0, "okay response");
        @(posedge clk);
        cfg[0] <= 1'h0;
        @(posedge clk);
        #1;
        checkPins(pullupEn, 4'hD, "reset pin pull-up one edge later");
        for (int k = 0; k < 10; k++)
        begin
            @(posedge clk);
            cfg <= cases[k];
            slow <= k[0];
            repeat (4) @(posedge clk);
            #1;
            e = expected(cases[k]);
            m = cases[k][1] ? 4'hB : 4'hF;
            checkPins(pullupEn, e[3:0], "pull-up");
            checkPins(padOe, e[7:4], "driver enable");
            checkPins(padOut & e[7:4] & m, e[11:8] & e[7:4] & m, "pin value");
            checkPins(pinChangeSrc, cases[k][22:19] & e[15:12], "pin-change inputs");
            checkPins({extIrq0In, timerCountSrc, extClockIn, captureInput},
                      {{2{cases[k][21] & e[14]}}, {2{cases[k][20] & e[13]}}},
                      "alternate inputs");
            if (cases[k][1])
                checkPins({3'h0, padOut[2]}, {3'h0, clk}, "clock output");
            ahb(1'h0, 32'h10, 32'h0, rd);
            checkWord(rd, {20'h0, e[15:12], e[3:0], e[7:4]}, "input enables");
            if (k == 0)
            begin
                ahb(1'h0, 32'h00, 32'h0, rd);
                checkWord(rd, {28'h0, cases[k][22:19]}, "pin read");
            end
        end
        // comparator pins: inputs with pull-ups off
        ahb(1'h1, 32'h0C, 32'h4, rd);
        ahb(1'h1, 32'h04, 32'hC, rd);
        #1;
        checkPins({padOe[1:0], pullupEn[1:0]}, 4'h0, "comparator pins idle");
        conclude();
    end
endmodule // port_alternate_function_override_tb_top
